// File: verif/midi_cc_chk.sv
// checker for the control-change mapper: bus answer and tx framing
// assumes one clock, async active-low reset, tx byte taken on valid&ready
`timescale 1ns/1ps
module midi_cc_chk (
    input wire I_CLK,
    input wire I_RST_N,
    input wire I_AVS_READ,
    input wire O_AVS_WAITREQUEST,
    input wire [7:0] O_TX_DATA,
    input wire O_TX_VALID,
    input wire I_TX_READY
);
    // ----
    // byte position inside the message being sent
    // ----
    reg [1:0] idx;
    reg [6:0] cc;
    wire take = O_TX_VALID && I_TX_READY;
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            idx <= 2'h0;
            cc <= 7'h00;
        end else if (take) begin
            idx <= (idx == 2'h2) ? 2'h0 : idx + 2'h1;
            if (idx == 2'h1)
                cc <= O_TX_DATA[6:0];
        end
    end
    wire last = O_TX_VALID && idx == 2'h2;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    sequence s_wait_one;
        O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
    endsequence
    sequence s_held;
        O_TX_VALID && $stable(O_TX_DATA);
    endsequence
    rd_answer_a: assert property ($rose(I_AVS_READ) |-> s_wait_one)
        else $error("read answer not one cycle late");
    tx_hold_a: assert property (O_TX_VALID && !I_TX_READY |=> s_held)
        else $error("tx byte dropped before taken");
    tx_status_a: assert property (O_TX_VALID && idx == 2'h0
        |-> O_TX_DATA[7:4] == 4'hb) else $error("first byte not a cc status");
    tx_seven_a: assert property (O_TX_VALID && idx != 2'h0
        |-> !O_TX_DATA[7]) else $error("data byte above 127");
    tx_gap_a: assert property (take && idx == 2'h2 |=> !O_TX_VALID)
        else $error("no idle cycle after message");
    glide_val_a: assert property (last && cc == 7'h41
        |-> O_TX_DATA == 8'h7f || O_TX_DATA == 8'h00)
        else $error("glide switch value not 0 or 127");
    group_val_a: assert property (last &&
        cc inside {7'h5c, 7'h5e, 7'h5f}
        |-> O_TX_DATA == 8'h7f || O_TX_DATA == 8'h00)
        else $error("group value not 0 or 127");
    cc_known_a: assert property (O_TX_VALID && idx == 2'h1
        |-> O_TX_DATA inside {8'h02, 8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b,
        8'h0c, 8'h0d, 8'h41, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f})
        else $error("unmapped controller sent");
endmodule // midi_cc_chk
bind midi_cc_control_mapper midi_cc_chk u_chk (
    .I_CLK(I_CLK),
    .I_RST_N(I_RST_N),
    .I_AVS_READ(I_AVS_READ),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .O_TX_DATA(O_TX_DATA),
    .O_TX_VALID(O_TX_VALID),
    .I_TX_READY(I_TX_READY)
);

// File: verif/midi_far_end.sv
// far-side instrument: takes tx bytes with random stalls, sends cc bytes
// assumes byte link on the mapper clock, channel 0 only
`timescale 1ns/1ps
module midi_far_end (
    input wire clk,
    input wire rst_n,
    input wire [7:0] tx_data,
    input wire tx_valid,
    output reg tx_ready,
    output reg [7:0] rx_data,
    output reg rx_valid
);
    integer seed = 32'h1cbc;
    reg [7:0] cap [$];
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    // stalls about one cycle in four to exercise the hold on tx
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            cap.push_back(tx_data);
        tx_ready <= rst_n && (($random(seed) & 3) != 0);
    end
    task send(input [6:0] cc, input [6:0] v);
        reg [23:0] m;
        integer k;
        begin
            m = {8'hb0, 1'b0, cc, 1'b0, v};
            for (k = 0; k < 3; k = k + 1) begin
                @(posedge clk);
                rx_data <= m[23:16];
                rx_valid <= 1'b1;
                @(posedge clk);
                rx_valid <= 1'b0;
                rx_data <= ~m[23:16];
                m = m << 8;
            end
            repeat (4) @(posedge clk);
        end
    endtask
endmodule // midi_far_end

// File: verif/testbench.sv
// self-checking bench for the control-change mapper
// assumes the mapper's hand-over timing; the far end model drives the link
`timescale 1ns/1ps
`include "midi_cc_defs.vh"
module testbench;
    reg I_CLK;
    reg I_RST_N;
    reg [5:0] addr;
    reg rd;
    reg wr;
    reg [31:0] wdata;
    wire [31:0] rdata;
    wire wait_req;
    wire [7:0] txd;
    wire [7:0] rxd;
    wire txv;
    wire txr;
    wire rxv;
    integer fails = 0;
    integer compares = 0;
    integer cycles = 0;
    integer seed = 32'h1cbc;
    integer k;
    integer v;
    integer vol;
    integer expr;
    reg [31:0] got;
    reg [27:0] gl = {7'd127, 7'd0, 7'd64, 7'd63};
    midi_cc_control_mapper u_dut (
        .I_CLK(I_CLK),
        .I_RST_N(I_RST_N),
        .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd),
        .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(4'hf),
        .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wait_req),
        .I_RX_DATA(rxd),
        .I_RX_VALID(rxv),
        .O_TX_DATA(txd),
        .O_TX_VALID(txv),
        .I_TX_READY(txr)
    );
    midi_far_end u_far (
        .clk(I_CLK),
        .rst_n(I_RST_N),
        .tx_data(txd),
        .tx_valid(txv),
        .tx_ready(txr),
        .rx_data(rxd),
        .rx_valid(rxv)
    );
    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end
    task stop_test;
        begin
            if (fails == 0 && compares > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge I_CLK) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            stop_test;
        end
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("unexpected at %0t: %h not %h", $time, seen, exp);
            end
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge
    task bus(input w, input [5:0] a, input [31:0] d);
        begin
            @(posedge I_CLK);
            addr <= a;
            wdata <= d;
            rd <= !w;
            wr <= w;
            @(posedge I_CLK);
            while (wait_req !== 1'b0)
                @(posedge I_CLK);
            got = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task msg(input [7:0] b1, input [7:0] b2);
        begin
            while (u_far.cap.size() < 3)
                @(posedge I_CLK);
            chk(u_far.cap.pop_front(), 8'hb0);
            chk(u_far.cap.pop_front(), b1);
            chk(u_far.cap.pop_front(), b2);
        end
    endtask
    initial begin
        I_RST_N = 1'b0;
        addr = 6'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        repeat (16) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        bus(0, `REG_TRACK_VAL, 0);
        chk(got, 32'd12700);
        bus(0, `REG_GLOBAL_VAL, 0);
        chk(got[6:0], 7'h40);
        bus(0, 6'h3c, 0);
        chk(got, 32'h0);
        vol = 100;
        expr = 127;
        for (k = 0; k < 3; k = k + 1) begin
            vol = $random(seed) & 127;
            u_far.send(`CC_VOLUME, vol);
            bus(0, `REG_TRACK_VAL, 0);
            chk(got[13:0], vol * expr);
            expr = $random(seed) & 127;
            u_far.send(`CC_EXPR, expr);
            bus(0, `REG_TRACK_VAL, 0);
            chk(got[13:0], vol * expr);
        end
        for (k = 0; k < 4; k = k + 1) begin
            v = gl[k*7 +: 7];
            u_far.send(`CC_GLIDE_SW, v);
            bus(0, `REG_TRACK_VAL, 0);
            chk(got[14], v >= 64);
        end
        u_far.send(`CC_PORT_TIME, 7'h2a);
        u_far.send(`CC_MOD2, 7'h15);
        bus(1, `REG_EVENT, 32'h1);
        bus(0, `REG_TRACK_VAL, 0);
        chk(got[30:24], 7'h2a);
        chk(got[22:16], 7'h15);
        chk(got[13:0], 32'd12700);
        v = $random(seed) & 127;
        bus(1, `REG_OPERATE, {17'h0, v[6:0], 1'b0, `CC_VOLUME});
        msg(8'h07, {1'b0, v[6:0]});
        bus(1, `REG_OPERATE, {17'h0, 7'd70, 1'b0, `CC_GLIDE_SW});
        msg(8'h41, 8'h7f);
        bus(1, `REG_OPERATE, {17'h0, 7'd10, 1'b0, `CC_GLIDE_SW});
        msg(8'h41, 8'h00);
        bus(1, `REG_MODE_CFG, 32'h0017f000);
        msg(8'h5c, 8'h00);
        bus(1, `REG_MODE_CFG, 32'h0007f000);
        msg(8'h5c, 8'h7f);
        u_far.send(`CC_GRP_MST1, 7'h00);
        bus(0, `REG_GLOBAL_VAL, 0);
        chk(got[26:24], 3'h2);
        u_far.send(`CC_GRP_MST1, 7'h01);
        bus(0, `REG_GLOBAL_VAL, 0);
        chk(got[26:24], 3'h0);
        bus(1, `REG_MODE_CFG, 32'h0007f002);
        bus(1, `REG_TRACK_SEL, 32'h0);
        bus(1, `REG_TRACK_CFG, {17'h0, 7'd100, 8'h09});
        u_far.send(`CC_MOD2, 7'h33);
        bus(1, `REG_OPERATE, {17'h0, 7'd5, 1'b0, `CC_MOD2});
        v = $random(seed) & 127;
        u_far.send(`CC_SEND_ONE, v);
        bus(0, `REG_SEND_VAL, 0);
        chk(got[13:0], v * 127);
        bus(0, `REG_TRACK_VAL, 0);
        chk(got[22:16], 7'h15);
        chk(u_far.cap.size(), 0);
        bus(1, `REG_TRACK_SET, {17'h0, 7'h22, 8'h00});
        msg(8'h07, 8'h22);
        stop_test;
    end
endmodule // testbench

// File: verilog/midi_cc_control_mapper.v
// control-change mapper: local controllers and received bytes to levels
// assumes byte-wide rx/tx links clocked by I_CLK; Avalon-MM master outside
//
// Behaviour
// R01: stick down sends and receives cc 02
// R02: stick enable gates cc 02 per track
// R03: cc 05 sets glide rate both ways
// R04: glide switch sends 127 on, 0 off
// R05: received glide switch: <=63 off, >=64 on
// R06: glide switch enable gates cc 65 per track
// R07: sequencer resends glide time and switch
// R08: cc 07 volume both ways
// R09: cc 11 expression both ways
// R10: level is volume times expression
// R11: song reselect reloads volume, expression maximum
// R12: combination reselect sends volume, external tracks
// R13: sequencer volume resend on change or reselect
// R14: cc 10 pan, 0 left 64 centre
// R15: pan resend, random pan never sent
// R16: cc 08 sets post insert effect pan
// R17: post pan channel depends on mode
// R18: cc 12 and 13 drive dynamic modulation
// R19: cc 91 and 93 set effect sends
// R20: send level is value times oscillator send outside program and sampling modes, value times 128 in those two
// R21: group disable sends 0, enable sends 127
// R22: received group cc: 0 off, else restore
// R23: receive internal/both, transmit both/external tracks
// R24: message is status, controller, value bytes
// R25: numbers and values are seven bits
`timescale 1ns/1ps
`include "midi_cc_defs.vh"
module midi_cc_control_mapper (
    input wire I_CLK,
    input wire I_RST_N,
    input wire [5:0] I_AVS_ADDRESS,
    input wire I_AVS_READ,
    input wire I_AVS_WRITE,
    input wire [31:0] I_AVS_WRITEDATA,
    input wire [3:0] I_AVS_BYTEENABLE,
    output reg [31:0] O_AVS_READDATA,
    output wire O_AVS_WAITREQUEST,
    input wire [7:0] I_RX_DATA,
    input wire I_RX_VALID,
    output reg [7:0] O_TX_DATA,
    output reg O_TX_VALID,
    input wire I_TX_READY
);

// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
function is_ext;
    input [1:0] s;
    is_ext = (s != `ST_INTERNAL_ONLY);
endfunction

function gated;
    input [2:0] m;
    gated = (m == `MODE_COMBI) || (m == `MODE_SEQ);
endfunction

function global_mode;
    input [2:0] m;
    global_mode = (m == `MODE_PROG) || (m == `MODE_SAMP);
endfunction

function [6:0] sw_val;
    input on;
    sw_val = on ? `VAL_MAX : `VAL_OFF;
endfunction

function [13:0] mul7;
    input [6:0] a;
    input [6:0] b;
    mul7 = a * b;
endfunction

// ----------------------------------------------------------------------
// state
// ----------------------------------------------------------------------
reg [2:0] mode;
reg [3:0] gch;
reg [3:0] fxch;
reg [6:0] osc_send;
reg [2:0] grp_dis;
reg [2:0] grp_pend;
reg [3:0] sel;
reg [6:0] post_pan;
reg [6:0] fx_ctl1;
reg [6:0] fx_ctl2;
reg rd_ack;

reg [1:0] st [0:15];
reg stk_en [0:15];
reg gl_en [0:15];
reg rnd [0:15];
reg [6:0] svol [0:15];
reg [6:0] vol [0:15];
reg [6:0] expr [0:15];
reg [6:0] pan [0:15];
reg [6:0] ptime [0:15];
reg psw [0:15];
reg [6:0] mod2 [0:15];
reg [6:0] send1 [0:15];
reg [6:0] send2 [0:15];

reg rx_have;
reg rx_phase;
reg [3:0] rx_ch;
reg [6:0] rx_cc;
reg rx_fire;
reg [3:0] rxf_ch;
reg [6:0] rxf_cc;
reg [6:0] rxf_val;

reg [1:0] tx_cnt;
reg [6:0] tx_cc;
reg [6:0] tx_val;

reg wk_busy;
reg [3:0] wk_trk;
reg [3:0] wk_end;
reg [1:0] wk_item;
reg wk_vol;
reg wk_pan;
reg wk_port;
reg wk_combi;

integer i;

// ----------------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------------
wire tx_busy = (tx_cnt != 2'h0);
wire busy_cmd = tx_busy | wk_busy | (|grp_pend) | rx_fire;
wire cmd_addr = (I_AVS_ADDRESS == `REG_OPERATE) ||
    (I_AVS_ADDRESS == `REG_EVENT) || (I_AVS_ADDRESS == `REG_TRACK_SET);
wire stall_w = cmd_addr & busy_cmd;
// a command write waits until the link and resend walker are idle
assign O_AVS_WAITREQUEST = I_AVS_READ ? ~rd_ack :
    (I_AVS_WRITE & stall_w);
wire wr = I_AVS_WRITE & ~I_AVS_READ & ~stall_w &
    (I_AVS_BYTEENABLE == 4'hf);
wire [31:0] wd = I_AVS_WRITEDATA;
wire wr_mc = wr & (I_AVS_ADDRESS == `REG_MODE_CFG);
wire wr_ev = wr & (I_AVS_ADDRESS == `REG_EVENT);
wire wr_op = wr & (I_AVS_ADDRESS == `REG_OPERATE);
wire wr_tc = wr & (I_AVS_ADDRESS == `REG_TRACK_CFG);
wire wr_ts = wr & (I_AVS_ADDRESS == `REG_TRACK_SET);

// ----------------------------------------------------------------------
// local controller operation
// ----------------------------------------------------------------------
wire [6:0] op_cc = wd[`OP_CC];
wire [6:0] op_val = wd[`OP_VAL];
wire [3:0] op_trk = global_mode(mode) ? gch : wd[`OP_TRK];
wire [3:0] op_ch = (!global_mode(mode) && op_cc == `CC_POST_PAN) ?
    fxch : op_trk; // R17
reg op_gate;
always @* begin
    op_gate = 1'b1;
    if (op_cc == `CC_MOD2)
        op_gate = !gated(mode) || stk_en[op_trk]; // R02
    else if (op_cc == `CC_GLIDE_SW)
        op_gate = !gated(mode) || gl_en[op_trk]; // R06
end
wire op_grp = (op_cc == `CC_GRP_INS) || (op_cc == `CC_GRP_MST1) ||
    (op_cc == `CC_GRP_MST2);
// group codes come from the mode register only, never from a controller
wire op_fire = wr_op & !op_grp & op_gate;
wire op_send = op_fire & (global_mode(mode) || is_ext(st[op_trk])); // R23
wire [6:0] op_txval = (op_cc == `CC_GLIDE_SW) ?
    sw_val(op_val >= `SW_ON_MIN) : op_val; // R04

// ----------------------------------------------------------------------
// apply: received message has priority, local writes stall meanwhile
// ----------------------------------------------------------------------
wire ap_rx = rx_fire;
wire ap_fire = rx_fire | op_fire;
wire [3:0] ap_trk = ap_rx ? rxf_ch : op_trk;
wire [6:0] ap_cc = ap_rx ? rxf_cc : op_cc;
wire [6:0] ap_val = ap_rx ? rxf_val : op_val;
wire rx_trk_ok = global_mode(mode) ? (rxf_ch == gch) :
    (st[rxf_ch] == `ST_INTERNAL_ONLY || st[rxf_ch] == `ST_BOTH_PORTS);
reg ap_ok;
always @* begin
    ap_ok = !ap_rx || rx_trk_ok; // R23
    if (ap_cc == `CC_MOD2)
        ap_ok = ap_ok && (!gated(mode) || stk_en[ap_trk]); // R02
    else if (ap_cc == `CC_GLIDE_SW)
        ap_ok = ap_ok && (!gated(mode) || gl_en[ap_trk]); // R06
    else if (ap_cc == `CC_POST_PAN)
        ap_ok = !ap_rx ||
            rxf_ch == (global_mode(mode) ? gch : fxch); // R17
end
wire grp_rx = rx_fire && rxf_ch == gch; // R22

// ----------------------------------------------------------------------
// resend walker item selection
// ----------------------------------------------------------------------
wire [1:0] wk_st = st[wk_trk];
wire wk_ok = wk_combi ? (wk_st == `ST_EXTERNAL_ONLY ||
    wk_st == `ST_EXTERNAL_ALT) : is_ext(wk_st); // R12 R23
reg wk_e;
reg [6:0] wk_cc;
reg [6:0] wk_v;
always @* begin
    case (wk_item)
    2'h0: begin
        wk_e = wk_vol; // R13
        wk_cc = `CC_VOLUME;
        wk_v = vol[wk_trk];
    end
    2'h1: begin
        wk_e = wk_pan && !rnd[wk_trk]; // R15
        wk_cc = `CC_PAN;
        wk_v = pan[wk_trk];
    end
    2'h2: begin
        wk_e = wk_port; // R07
        wk_cc = `CC_PORT_TIME;
        wk_v = ptime[wk_trk];
    end
    default: begin
        wk_e = wk_port && (!gated(mode) || gl_en[wk_trk]); // R07 R06
        wk_cc = `CC_GLIDE_SW;
        wk_v = sw_val(psw[wk_trk]);
    end
    endcase
end
wire wk_go = wk_busy & !tx_busy & !(|grp_pend);
wire wk_emit = wk_go & wk_e & wk_ok;

// ----------------------------------------------------------------------
// event decoding into walker passes
// ----------------------------------------------------------------------
wire seq = (mode == `MODE_SEQ);
wire ev_sr = wr_ev & wd[`EV_SONG_RESEL];
wire ev_ms = wr_ev & wd[`EV_MEASURE];
wire ev_ss = wr_ev & wd[`EV_SONG_START];
wire ev_cr = wr_ev & wd[`EV_COMBI_RESEL] & (mode == `MODE_COMBI);
wire sq_sp = seq || (mode == `MODE_SONG);
wire ts_vol = wr_ts && wd[`TS_WHICH] == `SET_VOL && sq_sp;
wire ts_pan = wr_ts && wd[`TS_WHICH] == `SET_PAN && sq_sp;
wire ts_port = wr_ts && wd[`TS_WHICH] >= `SET_PTIME && seq;
wire all_vol = ((ev_sr || ev_ss) && seq) || (ev_sr && mode == `MODE_SONG)
    || ev_cr; // R12 R13
wire all_pan = (ev_sr || ev_ms || ev_ss) && seq; // R15
wire all_port = (ev_sr || ev_ms || ev_ss) && seq; // R07
wire all_go = all_vol | all_pan | all_port;
wire one_go = ts_vol | ts_pan | ts_port;

always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        wk_busy <= 1'b0;
        wk_trk <= 4'h0;
        wk_end <= 4'h0;
        wk_item <= 2'h0;
        wk_vol <= 1'b0;
        wk_pan <= 1'b0;
        wk_port <= 1'b0;
        wk_combi <= 1'b0;
    end else if (all_go || one_go) begin
        wk_busy <= 1'b1;
        wk_trk <= all_go ? 4'h0 : sel;
        wk_end <= all_go ? 4'hf : sel;
        wk_item <= 2'h0;
        wk_vol <= all_vol | ts_vol;
        wk_pan <= all_pan | ts_pan;
        wk_port <= all_port | ts_port;
        wk_combi <= ev_cr;
    end else if (wk_go) begin
        wk_item <= wk_item + 2'h1;
        if (wk_item == 2'h3) begin
            wk_trk <= wk_trk + 4'h1;
            if (wk_trk == wk_end)
                wk_busy <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------
// transmit: three bytes per message, group changes first
// ----------------------------------------------------------------------
wire grp_go = (|grp_pend) & !tx_busy;
wire [1:0] grp_b = grp_pend[0] ? 2'h0 : (grp_pend[1] ? 2'h1 : 2'h2);
wire [6:0] grp_cc = (grp_b == 2'h0) ? `CC_GRP_INS :
    ((grp_b == 2'h1) ? `CC_GRP_MST1 : `CC_GRP_MST2);
wire [2:0] grp_clr = grp_go ? (3'h1 << grp_b) : 3'h0;
wire [2:0] grp_set = wr_mc ? (wd[`MC_GRP] ^ grp_dis) : 3'h0;
wire tx_step = O_TX_VALID & I_TX_READY;

always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        tx_cnt <= 2'h0;
        tx_cc <= 7'h00;
        tx_val <= 7'h00;
        O_TX_DATA <= 8'h00;
        O_TX_VALID <= 1'b0;
        grp_pend <= 3'h0;
    end else begin
        grp_pend <= (grp_pend & ~grp_clr) | grp_set; // R21
        if (grp_go || op_send || wk_emit) begin
            tx_cnt <= `MSG_BYTES;
            O_TX_VALID <= 1'b1;
            if (grp_go) begin
                tx_cc <= grp_cc;
                tx_val <= sw_val(!grp_dis[grp_b]); // R21
                O_TX_DATA <= {`STATUS_CC, gch}; // R24
            end else if (op_send) begin
                tx_cc <= op_cc;
                tx_val <= op_txval; // R01 R03 R08 R09 R14 R16 R18 R19
                O_TX_DATA <= {`STATUS_CC, op_ch}; // R24
            end else begin
                tx_cc <= wk_cc;
                tx_val <= wk_v;
                O_TX_DATA <= {`STATUS_CC, wk_trk}; // R24
            end
        end else if (tx_step) begin
            tx_cnt <= tx_cnt - 2'h1;
            O_TX_VALID <= (tx_cnt != 2'h1);
            O_TX_DATA <= (tx_cnt == 2'h3) ? {1'b0, tx_cc} :
                {1'b0, tx_val}; // R25
        end
    end
end

// ----------------------------------------------------------------------
// receive parser with running status
// ----------------------------------------------------------------------
always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        rx_have <= 1'b0;
        rx_phase <= 1'b0;
        rx_ch <= 4'h0;
        rx_cc <= 7'h00;
        rx_fire <= 1'b0;
        rxf_ch <= 4'h0;
        rxf_cc <= 7'h00;
        rxf_val <= 7'h00;
    end else begin
        rx_fire <= 1'b0;
        if (I_RX_VALID) begin
            if (I_RX_DATA[7]) begin
                // real-time bytes may interleave and leave state alone
                if (I_RX_DATA[7:3] != 5'h1f) begin
                    rx_have <= (I_RX_DATA[7:4] == `STATUS_CC); // R24
                    rx_ch <= I_RX_DATA[3:0];
                    rx_phase <= 1'b0;
                end
            end else if (rx_have) begin
                if (!rx_phase) begin
                    rx_cc <= I_RX_DATA[6:0]; // R25
                    rx_phase <= 1'b1;
                end else begin
                    rx_fire <= 1'b1;
                    rxf_ch <= rx_ch;
                    rxf_cc <= rx_cc;
                    rxf_val <= I_RX_DATA[6:0]; // R25
                    rx_phase <= 1'b0;
                end
            end
        end
    end
end

// ----------------------------------------------------------------------
// configuration and controller state
// ----------------------------------------------------------------------
always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        mode <= `MODE_PROG;
        gch <= 4'h0;
        fxch <= 4'h0;
        osc_send <= `VAL_MAX;
        grp_dis <= 3'h0;
        sel <= 4'h0;
        post_pan <= `RST_CENTRE;
        fx_ctl1 <= `VAL_OFF;
        fx_ctl2 <= `VAL_OFF;
        for (i = 0; i < 16; i = i + 1) begin
            st[i] <= `ST_INTERNAL_ONLY;
            stk_en[i] <= 1'b1;
            gl_en[i] <= 1'b1;
            rnd[i] <= 1'b0;
            svol[i] <= `RST_VOLUME;
            vol[i] <= `RST_VOLUME;
            expr[i] <= `VAL_MAX;
            pan[i] <= `RST_CENTRE;
            ptime[i] <= `VAL_OFF;
            psw[i] <= 1'b0;
            mod2[i] <= `VAL_OFF;
            send1[i] <= `VAL_OFF;
            send2[i] <= `VAL_OFF;
        end
    end else begin
        if (wr_mc) begin
            mode <= wd[`MC_MODE];
            gch <= wd[`MC_GCH];
            fxch <= wd[`MC_FXCH];
            osc_send <= wd[`MC_OSC];
        end
        if (wr & (I_AVS_ADDRESS == `REG_TRACK_SEL))
            sel <= wd[3:0];
        if (wr_tc) begin
            st[sel] <= wd[`TC_STATUS];
            stk_en[sel] <= wd[`TC_STICK];
            gl_en[sel] <= wd[`TC_GLIDE];
            rnd[sel] <= wd[`TC_RANDOM];
            svol[sel] <= wd[`TC_SVOL];
        end
        if (ev_sr || ev_ss) begin
            for (i = 0; i < 16; i = i + 1) begin
                vol[i] <= svol[i]; // R11
                expr[i] <= `VAL_MAX; // R11
            end
        end
        if (wr_ts) begin
            case (wd[`TS_WHICH])
            `SET_VOL: vol[sel] <= wd[`TS_VAL];
            `SET_PAN: pan[sel] <= wd[`TS_VAL];
            `SET_PTIME: ptime[sel] <= wd[`TS_VAL];
            default: psw[sel] <= (wd[`TS_VAL] >= `SW_ON_MIN);
            endcase
        end
        if (wr_mc)
            grp_dis <= wd[`MC_GRP]; // R21
        if (grp_rx) begin
            case (rxf_cc)
            `CC_GRP_INS: grp_dis[0] <= (rxf_val == `VAL_OFF); // R22
            `CC_GRP_MST1: grp_dis[1] <= (rxf_val == `VAL_OFF); // R22
            `CC_GRP_MST2: grp_dis[2] <= (rxf_val == `VAL_OFF); // R22
            default: ;
            endcase
        end
        if (ap_fire && ap_ok) begin
            case (ap_cc)
            `CC_MOD2: mod2[ap_trk] <= ap_val; // R01
            `CC_PORT_TIME: ptime[ap_trk] <= ap_val; // R03
            `CC_GLIDE_SW: psw[ap_trk] <= (ap_val >= `SW_ON_MIN); // R04 R05
            `CC_VOLUME: vol[ap_trk] <= ap_val; // R08
            `CC_EXPR: expr[ap_trk] <= ap_val; // R09
            `CC_PAN: pan[ap_trk] <= ap_val; // R14
            `CC_POST_PAN: post_pan <= ap_val; // R16
            `CC_FX_CTL1: fx_ctl1 <= ap_val; // R18
            `CC_FX_CTL2: fx_ctl2 <= ap_val; // R18
            `CC_SEND_ONE: send1[ap_trk] <= ap_val; // R19
            `CC_SEND_TWO: send2[ap_trk] <= ap_val; // R19
            default: ;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// readback; reads answer on the second edge
// ----------------------------------------------------------------------
wire [13:0] level = mul7(vol[sel], expr[sel]); // R10
wire scaled = !global_mode(mode);
wire [13:0] eff1 = scaled ? mul7(send1[sel], osc_send) :
    {send1[sel], 7'h00}; // R20
wire [13:0] eff2 = scaled ? mul7(send2[sel], osc_send) :
    {send2[sel], 7'h00}; // R20
reg [31:0] rdata;
always @* begin
    rdata = 32'h0;
    case (I_AVS_ADDRESS)
    `REG_MODE_CFG: begin
        rdata[`MC_MODE] = mode;
        rdata[`MC_GCH] = gch;
        rdata[`MC_FXCH] = fxch;
        rdata[`MC_OSC] = osc_send;
        rdata[`MC_GRP] = grp_dis;
    end
    `REG_EVENT: rdata[1:0] = {tx_busy, wk_busy};
    `REG_TRACK_SEL: rdata[3:0] = sel;
    `REG_TRACK_CFG: begin
        rdata[`TC_STATUS] = st[sel];
        rdata[`TC_STICK] = stk_en[sel];
        rdata[`TC_GLIDE] = gl_en[sel];
        rdata[`TC_RANDOM] = rnd[sel];
        rdata[`TC_SVOL] = svol[sel];
    end
    `REG_TRACK_SET: rdata = {1'b0, pan[sel], 1'b0, expr[sel],
        1'b0, vol[sel], 8'h00};
    `REG_TRACK_VAL: rdata = {1'b0, ptime[sel], 1'b0, mod2[sel],
        1'b0, psw[sel], level};
    `REG_SEND_VAL: rdata = {2'h0, eff2, 2'h0, eff1};
    `REG_GLOBAL_VAL: rdata = {5'h0, grp_dis, 1'b0, fx_ctl2,
        1'b0, fx_ctl1, 1'b0, post_pan};
    default: rdata = 32'h0;
    endcase
end

always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        rd_ack <= 1'b0;
        O_AVS_READDATA <= 32'h0;
    end else begin
        rd_ack <= I_AVS_READ & ~rd_ack;
        if (I_AVS_READ & ~rd_ack)
            O_AVS_READDATA <= rdata;
    end
end

endmodule // midi_cc_control_mapper

// File: verilog/midi_cc_defs.vh
// constants for the control-change mapper: offsets, fields, codes, resets
// assumes inclusion by the mapper and the testbench; definitions, no logic
`ifndef MIDI_CC_DEFS_VH
`define MIDI_CC_DEFS_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_MODE_CFG 6'h00
`define REG_EVENT 6'h04
`define REG_OPERATE 6'h08
`define REG_TRACK_SEL 6'h0c
`define REG_TRACK_CFG 6'h10
`define REG_TRACK_SET 6'h14
`define REG_TRACK_VAL 6'h18
`define REG_SEND_VAL 6'h1c
`define REG_GLOBAL_VAL 6'h20
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MC_MODE 2:0
`define MC_GCH 7:4
`define MC_FXCH 11:8
`define MC_OSC 18:12
`define MC_GRP 22:20
`define EV_SONG_RESEL 0
`define EV_MEASURE 1
`define EV_SONG_START 2
`define EV_COMBI_RESEL 3
`define OP_CC 6:0
`define OP_VAL 14:8
`define OP_TRK 19:16
`define TC_STATUS 1:0
`define TC_STICK 2
`define TC_GLIDE 3
`define TC_RANDOM 4
`define TC_SVOL 14:8
`define TS_WHICH 1:0
`define TS_VAL 14:8
// ----------------------------------------------------------------------
// modes and routing status
// ----------------------------------------------------------------------
`define MODE_PROG 3'h0
`define MODE_COMBI 3'h1
`define MODE_SEQ 3'h2
`define MODE_SONG 3'h3
`define MODE_SAMP 3'h4
`define ST_INTERNAL_ONLY 2'h0
`define ST_BOTH_PORTS 2'h1
`define ST_EXTERNAL_ONLY 2'h2
`define ST_EXTERNAL_ALT 2'h3
`define SET_VOL 2'h0
`define SET_PAN 2'h1
`define SET_PTIME 2'h2
`define SET_PSW 2'h3
// ----------------------------------------------------------------------
// controller numbers and values
// ----------------------------------------------------------------------
`define STATUS_CC 4'hb
`define CC_MOD2 7'h02
`define CC_PORT_TIME 7'h05
`define CC_VOLUME 7'h07
`define CC_POST_PAN 7'h08
`define CC_PAN 7'h0a
`define CC_EXPR 7'h0b
`define CC_FX_CTL1 7'h0c
`define CC_FX_CTL2 7'h0d
`define CC_GLIDE_SW 7'h41
`define CC_SEND_TWO 7'h5b
`define CC_GRP_INS 7'h5c
`define CC_SEND_ONE 7'h5d
`define CC_GRP_MST1 7'h5e
`define CC_GRP_MST2 7'h5f
`define VAL_MAX 7'h7f
`define VAL_OFF 7'h00
`define SW_ON_MIN 7'h40
`define RST_VOLUME 7'h64
`define RST_CENTRE 7'h40
`define MSG_BYTES 2'h3
`endif
